//--- rtl/msp_switch.sv
// Linear section protection switch with bridge, selector and APS handling.
// Contract
// - 1+1 normal output from working or protection
// - 1:n normal i from working i or protection
// - Select from fail, degrade, command, APS
// - Working outputs always carry their normal inputs
// - 1+1 protection output unsourced or normal input
// - 1:n protection output may carry extra traffic
// - Config changes only apply while idle
// - Unidirectional or bidirectional switching configurable
// - 1+1 revertive or non-revertive configurable
// - Thirteen-bit APS channel exchanged both ways
// - Configurable wait-to-restore before reverting
// - Switch within 50 ms, no hold-off
// - Revertive 1+1 command set accepted
// - Non-revertive 1+1 command set accepted
// - 1:n command set accepted
// - 1:n up to 14 sections, revertive only
// - Idle protection output carries null signal (in 1+1 the code bridges normal input one there instead)
// - On switch extra output all ones, fail
// - Trail source passes signal unchanged
// - APS value accepted after three equal frames
`timescale 1ns/1ps
`default_nettype none
module msp_switch #(
  parameter int TICK_N = msp_pkg::TICK_CYC,  // Cycles per wait-to-restore second.
  parameter int FOP_N  = msp_pkg::FOP_CYC    // Cycles of mismatch before failure.
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output var  logic                     hreadyout,
  output var  logic                     hresp,
  output var  logic [31:0]              hrdata,
  input  wire msp_pkg::msp_sec_s [13:0] work_in,
  input  wire msp_pkg::msp_sec_s        prot_in,
  input  wire msp_pkg::msp_sec_s [13:0] norm_in,
  input  wire msp_pkg::msp_sec_s        extra_in,
  input  wire msp_pkg::msp_sec_s        pts_in,
  input  wire logic [14:0]              server_fail_in,
  input  wire logic [14:0]              server_degrade_in,
  input  wire logic [12:0]              aps_rx,
  output var  msp_pkg::msp_sec_s [13:0] work_out,
  output var  msp_pkg::msp_sec_s        prot_out,
  output var  msp_pkg::msp_sec_s [13:0] norm_out,
  output var  logic [13:0]              norm_fail,
  output var  msp_pkg::msp_sec_s        extra_out,
  output var  logic                     fail_action,
  output var  msp_pkg::msp_sec_s        pts_out,
  output var  logic [12:0]              aps_tx,
  output var  logic                     protocol_failure,
  output var  logic [15:0]              switch_count,
  output var  logic [15:0]              switch_duration
);
  import msp_pkg::*;

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  // Every stream, its clock and its frame start come from other domains.
  msp_sec_s [13:0] wk_m_q, wk_q, nm_m_q, nm_q;  // Working and normal inputs.
  msp_sec_s        pr_m_q, pr_q, ex_m_q, ex_q;  // Protection and extra inputs.
  msp_sec_s        ts_m_q, ts_q;                // Trail source input.
  logic [14:0]     sf_m_q, sf_q, sd_m_q, sd_q;  // Fail and degrade, index 0 protection.
  logic [12:0]     ap_m_q, ap_q;                // Received channel.

  // Two flops per input; only the second stage feeds any logic.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {wk_m_q, wk_q, nm_m_q, nm_q} <= '0;
      {pr_m_q, pr_q, ex_m_q, ex_q, ts_m_q, ts_q} <= '0;
      {sf_m_q, sf_q, sd_m_q, sd_q, ap_m_q, ap_q} <= '0;
    end
    else
    begin
      {wk_m_q, nm_m_q, pr_m_q, ex_m_q} <= {work_in, norm_in, prot_in, extra_in};
      {wk_q, nm_q, pr_q, ex_q} <= {wk_m_q, nm_m_q, pr_m_q, ex_m_q};
      {ts_m_q, sf_m_q, sd_m_q, ap_m_q} <= {pts_in, server_fail_in, server_degrade_in, aps_rx};
      {ts_q, sf_q, sd_q, ap_q} <= {ts_m_q, sf_m_q, sd_m_q, ap_m_q};
    end
  end

  // ****************************************************************
  // Register bus slave.
  // ****************************************************************
  msp_cfg_s    cfg_q, act_q;   // Written and applied configuration.
  logic [7:0]  cmd_q;          // External command: type high, section low.
  logic        dp_wr_q;        // Write data phase pending.
  logic [7:0]  dp_a_q;         // Address of pending write.
  msp_state_e  st_q, st_d;     // Protection state.
  logic [3:0]  sel_q, sel_d;   // Section selected from protection, zero none.
  logic [3:0]  code_d, ch_d;   // Winning request and its section.
  logic [12:0] acc_q;          // Accepted received channel.
  logic        fop_q;          // Protocol failure.
  logic        wtr_on;         // Wait-to-restore running.

  // Read decode, used by the read path below.
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      OFS_CTRL:   rd_word = {28'h000_0000, cfg_q.extra_en, cfg_q.revert, cfg_q.bidir,
                             cfg_q.arch_1n};
      OFS_WTR:    rd_word = {22'h00_0000, cfg_q.wtr_s};
      OFS_CMD:    rd_word = {24'h00_0000, cmd_q};
      OFS_STATUS: rd_word = {3'h0, acc_q, 3'h0, fop_q, wtr_on, 3'h0, sel_q, code_d};
      OFS_COUNT:  rd_word = {16'h0000, switch_count};
      OFS_DUR:    rd_word = {16'h0000, switch_duration};
      default:    rd_word = 32'h0000_0000;  // Unmapped reads return zero.
    endcase
  endfunction : rd_word

  // Address phase is latched; read data is ready with the data phase, no waits.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {dp_wr_q, dp_a_q, hrdata, hreadyout, hresp} <= '0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_wr_q   <= hsel && htrans[1] && hready && hwrite;
      dp_a_q    <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        hrdata <= rd_word(haddr[7:0]);
      end
    end
  end

  // Software writes; the applied copy only follows while nothing is switched.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg_q <= '{1'b0, 1'b0, 1'b0, 1'b0, WTR_RST};
      act_q <= '{1'b0, 1'b0, 1'b0, 1'b0, WTR_RST};
      cmd_q <= CMD_RST;
    end
    else
    begin
      if (dp_wr_q && dp_a_q == OFS_CTRL)
      begin
        // A 1:n group always reverts, so revert is forced on there.
        cfg_q.arch_1n  <= hwdata[0];
        cfg_q.bidir    <= hwdata[1];
        cfg_q.revert   <= hwdata[2] | hwdata[0];
        cfg_q.extra_en <= hwdata[3];
      end
      if (dp_wr_q && dp_a_q == OFS_WTR)
      begin
        cfg_q.wtr_s <= hwdata[9:0];
      end
      if (dp_wr_q && dp_a_q == OFS_CMD)
      begin
        cmd_q <= hwdata[7:0];
      end
      // Changes land only when no switch is active or required.
      if (st_q == ST_IDLE && sel_d == 4'h0)
      begin
        act_q <= cfg_q;
      end
    end
  end

  // ****************************************************************
  // Received channel: three equal frames before acceptance.
  // ****************************************************************
  logic        fs_d1_q;   // Protection frame start, previous sample.
  logic [12:0] cand_q;    // Value under test.
  logic [1:0]  agree_q;   // Frames it has matched.
  wire         pfs = pr_q.fs && !fs_d1_q;

  // A mismatching frame restarts the count with the new candidate.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {fs_d1_q, cand_q, agree_q, acc_q} <= '0;
    end
    else
    begin
      fs_d1_q <= pr_q.fs;
      if (pfs)
      begin
        if (ap_q != cand_q)
        begin
          cand_q  <= ap_q;
          agree_q <= 2'd1;
        end
        else if (agree_q != 2'(APS_AGREE))
        begin
          agree_q <= agree_q + 2'd1;
        end
        if (ap_q == cand_q && agree_q == 2'(APS_AGREE - 1))
        begin
          acc_q <= cand_q;
        end
      end
    end
  end

  // ****************************************************************
  // Request priority and the selector state machine.
  // ****************************************************************
  logic [3:0] cmd_ch;     // Command section, fixed at one for 1+1.
  logic       cmd_ok;     // Command section is in range.
  logic [3:0] rem_code, rem_ch, loc_code, loc_ch, tx_code;
  logic       sfsd_q;     // Last switch was caused by fail or degrade.
  logic [9:0] wtr_q;      // Seconds left of wait-to-restore.
  logic [25:0] tick_q;    // Second prescaler.
  wire        tick = tick_q == 26'(TICK_N - 1);

  assign wtr_on = st_q == ST_WTR;

  // Highest local request wins, except that exercise displaces wait-to-restore; a stronger far-end request wins in bidir.
  always_comb
  begin
    cmd_ch   = act_q.arch_1n ? cmd_q[3:0] : 4'h1;
    cmd_ok   = cmd_ch != 4'h0 && cmd_ch <= 4'(NW);
    loc_code = REQ_NR;
    loc_ch   = 4'h0;
    if (st_q == ST_WTR) begin loc_code = REQ_WTR; loc_ch = sel_q; end
    if (st_q == ST_HOLD) begin loc_code = REQ_DNR; loc_ch = sel_q; end
    if (cmd_q[7:4] == CMD_EXERCISE && cmd_ok) begin loc_code = REQ_EX; loc_ch = cmd_ch; end
    if (cmd_q[7:4] == CMD_MANUAL && cmd_ok) begin loc_code = REQ_MS; loc_ch = cmd_ch; end
    for (int i = NW; i >= 1; i--)
    begin
      if (sd_q[i] && i <= (act_q.arch_1n ? NW : 1))
      begin
        loc_code = REQ_SD;
        loc_ch   = 4'(i);
      end
    end
    for (int i = NW; i >= 1; i--)
    begin
      if (sf_q[i] && i <= (act_q.arch_1n ? NW : 1))
      begin
        loc_code = REQ_SF;
        loc_ch   = 4'(i);
      end
    end
    if (cmd_q[7:4] == CMD_FORCED && cmd_ok) begin loc_code = REQ_FS; loc_ch = cmd_ch; end
    if (sf_q[0]) begin loc_code = REQ_SFP; loc_ch = 4'h0; end
    if (cmd_q[7:4] == CMD_LOCKOUT) begin loc_code = REQ_LO; loc_ch = 4'h0; end
    rem_code = acc_q[APS_CODE +: 4];
    rem_ch   = acc_q[APS_CH +: 4];
    code_d   = loc_code;
    ch_d     = loc_ch;
    tx_code  = loc_code;
    if (act_q.bidir && rem_code > loc_code && rem_code != REQ_RR)
    begin
      code_d  = rem_code;
      ch_d    = rem_ch;
      tx_code = REQ_RR;
    end
  end

  // Next state: no hold-off, the switch follows the request at once.
  always_comb
  begin
    st_d  = st_q;
    sel_d = sel_q;
    case (st_q)
      ST_IDLE:
      begin
        if (code_d >= REQ_MS && ch_d != 4'h0) begin st_d = ST_SWITCHED; sel_d = ch_d; end
      end
      ST_SWITCHED, ST_WTR, ST_HOLD:
      begin
        if (code_d >= REQ_MS && ch_d != 4'h0)
        begin
          st_d  = ST_SWITCHED;
          sel_d = ch_d;
        end
        else if (code_d >= REQ_MS || (st_q == ST_WTR && wtr_q == 10'h000))
        begin
          st_d  = ST_IDLE;
          sel_d = 4'h0;
        end
        else if (st_q == ST_SWITCHED)
        begin
          // Non-revertive holds; otherwise only fail or degrade recovery waits and a cleared command reverts at once.
          if (!act_q.revert) st_d = ST_HOLD;
          else if (sfsd_q) st_d = ST_WTR;
          else begin st_d = ST_IDLE; sel_d = 4'h0; end
        end
      end
      default:
      begin
        st_d  = ST_IDLE;
        sel_d = 4'h0;
      end
    endcase
  end

  // State, wait-to-restore countdown and the second prescaler.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q   <= ST_IDLE;
      {sel_q, sfsd_q, wtr_q, tick_q} <= '0;
    end
    else
    begin
      st_q   <= st_d;
      sel_q  <= sel_d;
      tick_q <= tick ? 26'h000_0000 : tick_q + 26'h000_0001;
      if (st_d == ST_SWITCHED && code_d >= REQ_MS)
      begin
        sfsd_q <= code_d == REQ_SF || code_d == REQ_SD;
      end
      if (st_q != ST_WTR)
      begin
        wtr_q <= act_q.wtr_s;
      end
      else if (tick && wtr_q != 10'h000)
      begin
        wtr_q <= wtr_q - 10'h001;
      end
    end
  end

  // ****************************************************************
  // Bridge, selector and trail source data paths.
  // ****************************************************************
  logic [3:0] br_ch;  // Normal input bridged onto protection.

  // A 1+1 group bridges section one permanently; 1:n bridges the request.
  always_comb
  begin
    br_ch = act_q.arch_1n ? ((code_d >= REQ_MS) ? ch_d : sel_q) : 4'h1;
  end

  // All stream outputs are registered from synchronised inputs; unbridged protection without extra traffic and switched extra get all-ones data.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {work_out, norm_out, norm_fail, prot_out} <= '0;
      {extra_out, fail_action, pts_out, aps_tx} <= '0;
    end
    else
    begin
      work_out <= nm_q;
      for (int i = 0; i < NW; i++)
      begin
        norm_out[i]  <= (sel_q == 4'(i + 1)) ? pr_q : wk_q[i];
        norm_fail[i] <= (sel_q == 4'(i + 1)) ? sf_q[0] : sf_q[i + 1];
      end
      if (br_ch != 4'h0 && br_ch <= 4'(NW))
        prot_out <= nm_q[br_ch - 4'h1];
      else if (act_q.arch_1n && act_q.extra_en)
        prot_out <= ex_q;
      else
        prot_out <= '{8'hFF, nm_q[0].ck, nm_q[0].fs};
      if (sel_q != 4'h0)
      begin
        extra_out   <= '{8'hFF, pr_q.ck, pr_q.fs};
        fail_action <= 1'b1;
      end
      else
      begin
        extra_out   <= pr_q;
        fail_action <= sf_q[0];
      end
      pts_out <= ts_q;
      aps_tx  <= {tx_code, ch_d, br_ch, act_q.arch_1n};
    end
  end

  // ****************************************************************
  // Management: protocol failure, switch count and duration.
  // ****************************************************************
  logic [21:0] fop_cnt_q;  // Cycles of bridge or architecture mismatch.
  wire mism = act_q.bidir && (acc_q[APS_BR +: 4] != ch_d || acc_q[APS_ARCH] != act_q.arch_1n);

  // Mismatch must persist past the switch time before it is declared.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {fop_cnt_q, fop_q, switch_count, switch_duration} <= '0;
    end
    else
    begin
      fop_cnt_q <= !mism ? 22'h00_0000 :
                   (fop_cnt_q == 22'(FOP_N) ? fop_cnt_q : fop_cnt_q + 22'h00_0001);
      fop_q     <= mism && fop_cnt_q == 22'(FOP_N);
      if (sel_q == 4'h0 && sel_d != 4'h0)
      begin
        switch_count    <= switch_count + 16'h0001;
        switch_duration <= 16'h0000;
      end
      else if (sel_q != 4'h0 && tick && switch_duration != 16'hFFFF)
      begin
        switch_duration <= switch_duration + 16'h0001;
      end
    end
  end
  assign protocol_failure = fop_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_SEL_PATH: assert property (sel_q == 4'h1 && $past(sel_q) == 4'h1 |=>
    norm_out[0] == $past(pr_q)) else $error("normal one not from protection");
  AST_WORK_PATH: assert property (sel_q != 4'h3 |=> norm_out[2] == $past(wk_q[2]))
    else $error("normal three not from working three");
  AST_BRIDGE: assert property (##1 work_out == $past(nm_q))
    else $error("working output not bridged");
  AST_LOCKOUT: assert property (cmd_q[7:4] == CMD_LOCKOUT |=> sel_q == 4'h0)
    else $error("lockout left a switch");
  AST_SF_FAST: assert property (code_d == REQ_SF && st_q == ST_IDLE |=> sel_q == $past(ch_d))
    else $error("fail did not switch in one cycle");
  AST_EXTRA_AIS: assert property (sel_q != 4'h0 |=> extra_out.data == 8'hFF && fail_action)
    else $error("extra traffic not squelched");
  AST_NULL: assert property (br_ch == 4'h0 && !act_q.extra_en |=>
    prot_out.data == 8'hFF) else $error("null signal missing");
  AST_CFG_IDLE: assert property ($changed(act_q) |-> $past(st_q) == ST_IDLE)
    else $error("configuration applied during switch");
  AST_REVERT_1N: assert property (act_q.arch_1n |-> act_q.revert)
    else $error("non-revertive 1:n");
  AST_APS3: assert property ($changed(acc_q) |-> $past(pfs) && $past(agree_q) == 2'd2
    && $past(ap_q) == acc_q) else $error("channel accepted too early");
  AST_PTS: assert property (##2 pts_out == $past(pts_in, 3))
    else $error("trail source altered signal");
  AST_COUNT: assert property ($past(sel_q) == 4'h0 && sel_q != 4'h0 |->
    switch_count == $past(switch_count) + 16'h0001) else $error("switch not counted");

  COV_SWITCH: cover property (st_q == ST_IDLE ##1 st_q == ST_SWITCHED);
  COV_WTR_DONE: cover property (st_q == ST_WTR ##1 st_q == ST_IDLE);
  COV_HOLD: cover property (st_q == ST_HOLD);
  COV_REMOTE: cover property (tx_code == REQ_RR && sel_q != 4'h0);

endmodule : msp_switch
`default_nettype wire

//--- rtl/msp_pkg.sv
// Constants, register map and carrier types of the section protection switch.
package msp_pkg;

  // ****************************************************************
  // Sizes and timing.
  // ****************************************************************
  localparam int NW          = 14;          // Working sections in 1:n.
  localparam int CLK_HZ      = 40_000_000;  // Core clock rate.
  localparam int WTR_UNIT_S  = 1;           // Wait-to-restore unit, seconds.
  localparam int TICK_CYC    = WTR_UNIT_S * CLK_HZ;
  localparam int SW_TIME_MS  = 50;          // Longest switch completion time.
  localparam int FOP_CYC     = SW_TIME_MS * (CLK_HZ / 1000);
  localparam int APS_AGREE   = 3;           // Equal frames before acceptance.

  // ****************************************************************
  // Register offsets and reset values.
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WTR    = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_DUR    = 8'h14;
  localparam logic [9:0] WTR_RST    = 10'h12C;  // 300 seconds.
  localparam logic [7:0] CMD_RST    = 8'h00;

  // Field positions inside the 13-bit protection channel.
  localparam int APS_CODE = 9;   // Request code, four bits.
  localparam int APS_CH   = 5;   // Requested section, four bits.
  localparam int APS_BR   = 1;   // Bridged section, four bits.
  localparam int APS_ARCH = 0;   // Architecture bit.

  // ****************************************************************
  // Request codes, higher value wins except exercise over wait-to-restore; command types.
  // ****************************************************************
  localparam logic [3:0] REQ_LO  = 4'hF, REQ_SFP = 4'hE, REQ_FS = 4'hD;
  localparam logic [3:0] REQ_SF  = 4'hC, REQ_SD  = 4'hA, REQ_MS = 4'h8;
  localparam logic [3:0] REQ_WTR = 4'h6, REQ_EX  = 4'h4, REQ_RR = 4'h2;
  localparam logic [3:0] REQ_DNR = 4'h1, REQ_NR  = 4'h0;
  localparam logic [3:0] CMD_CLEAR = 4'h0, CMD_LOCKOUT = 4'h1, CMD_FORCED = 4'h2;
  localparam logic [3:0] CMD_MANUAL = 4'h3, CMD_EXERCISE = 4'h4;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef struct packed {
    logic [7:0] data;  // Payload.
    logic       ck;    // Signal's own clock, sampled.
    logic       fs;    // Frame start.
  } msp_sec_s;

  typedef struct packed {
    logic       arch_1n;   // One for 1:n, zero for 1+1.
    logic       bidir;     // Bidirectional switching.
    logic       revert;    // Revertive operation.
    logic       extra_en;  // Extra traffic on protection.
    logic [9:0] wtr_s;     // Wait-to-restore time in seconds.
  } msp_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_SWITCHED = 4'b0010, ST_WTR = 4'b0100, ST_HOLD = 4'b1000
  } msp_state_e;

endpackage : msp_pkg

//--- bench/msp_far_end.sv
// Far-end node model: protection line stream with frame starts and APS channel.
`timescale 1ns/1ps
`default_nettype none
module msp_far_end
  import msp_pkg::*;
(
  input  wire logic [12:0]      aps_req,
  output var  msp_pkg::msp_sec_s line,
  output var  logic [12:0]      aps_rx
);
  logic       ck  = 1'b0;  // Line clock, free running like a real section.
  logic [1:0]  pos  = 2'd0;      // Position inside a four-clock frame.
  logic [12:0] rx_q = 13'h0000;  // Channel value on the line.
  assign aps_rx = rx_q;
  // The phase offset keeps line clock edges off core clock edges; the line period is eight core cycles.
  initial
  begin
    #37;
    forever #100 ck = ~ck;
  end
  // The channel changes mid-frame, so each frame start sees one settled value.
  always @(posedge ck)
  begin
    pos <= pos + 2'd1;
    if (pos == 2'd2)
      rx_q <= aps_req;
  end
  assign line = '{data: 8'hA5, ck: ck, fs: pos == 2'd0};
endmodule : msp_far_end
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register access, traffic paths and switching behaviour.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import msp_pkg::*;
  logic            core_clk = 1'b0;
  logic            rst_n    = 1'b0;
  logic [1:0]      htrans   = 2'b00;
  logic            hwrite   = 1'b0;
  logic [31:0]     haddr    = '0, hwdata = '0, hrdata, q;
  logic            hreadyout, fail_action;
  msp_sec_s [13:0] work_in, norm_in, work_out, norm_out;
  msp_sec_s        prot_in, extra_in, pts_in, prot_out, extra_out, pts_out;
  logic [14:0]     sf = '0, sd = '0;
  logic [12:0]     aps_rx, aps_req = 13'h0002;
  logic [12:0]     aps_tx;
  logic [13:0]     nfail;
  logic [15:0]     sw_cnt, sw_dur;
  logic            pfail;
  int              fails = 0, num_checks = 0;
  logic [3:0] cmd_t [4] = '{CMD_LOCKOUT, CMD_FORCED, CMD_MANUAL, CMD_EXERCISE};
  logic [3:0] code_t [4] = '{REQ_LO, REQ_FS, REQ_MS, REQ_EX};
  logic [7:0] dat_t [4] = '{8'h40, 8'hA5, 8'hA5, 8'h40};
  always #12.5 core_clk = ~core_clk;
  msp_far_end far (.aps_req(aps_req), .line(prot_in), .aps_rx(aps_rx));
  // Short second and failure timers keep the run brief.
  msp_switch #(.TICK_N(20), .FOP_N(30)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .work_in(work_in),
    .prot_in(prot_in), .norm_in(norm_in), .extra_in(extra_in), .pts_in(pts_in),
    .server_fail_in(sf), .server_degrade_in(sd), .aps_rx(aps_rx), .work_out(work_out),
    .prot_out(prot_out), .norm_out(norm_out), .norm_fail(nfail), .extra_out(extra_out),
    .fail_action(fail_action), .pts_out(pts_out), .aps_tx(aps_tx), .protocol_failure(pfail),
    .switch_count(sw_cnt), .switch_duration(sw_dur));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
      begin
        fails++;
        $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
  endtask : chk
  // Waits for hready sampled high; a hung bus ends the run.
  task automatic hwait();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      report_and_stop();
    end
  endtask : hwait
  // One single AHB transfer; read data lands in q.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr  <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    hwait();
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask : xfer
  // ****************************************
  // Main sequence.
  // ****************************************
  initial
  begin
    work_in = '0;
    norm_in = '0;
    for (int i = 0; i < 14; i++)
    begin
      work_in[i].data = 8'h40 + 8'(i);
      norm_in[i].data = 8'h10 + 8'(i);
    end
    extra_in = '{data: 8'hE5, ck: 1'b1, fs: 1'b0};
    pts_in = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(0, OFS_WTR, 0);
    chk(q, 32'(WTR_RST));
    xfer(0, 8'h40, 0);
    chk(q, 0);
    pts_in <= '{data: 8'h77, ck: 1'b1, fs: 1'b1};
    repeat (150) @(posedge core_clk);
    chk(32'(pts_out), 32'(pts_in));
    chk(32'(work_out[13]), 32'(norm_in[13]));
    chk(32'(norm_out[0].data), 32'h40);
    chk(32'(prot_out.data), 32'h10);
    $display("reset and traffic test done");
    // A changed channel value is not taken before three frames.
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[28:16]), 32'h0002);
    aps_req <= 13'h0004;
    repeat (20) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[28:16]), 32'h0002);
    repeat (150) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[28:16]), 32'h0004);
    $display("channel test done");
    xfer(1, OFS_CTRL, 32'h0000_0004);
    xfer(1, OFS_WTR, 32'h0000_0001);
    xfer(0, OFS_CTRL, 0);
    chk(q, 32'h0000_0004);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1, OFS_CMD, 32'({cmd_t[i], 4'h1}));
      repeat (10) @(posedge core_clk);
      xfer(0, OFS_STATUS, 0);
      chk(32'(q[3:0]), 32'(code_t[i]));
      chk(32'(norm_out[0].data), 32'(dat_t[i]));
      xfer(1, OFS_CMD, 32'(CMD_CLEAR));
      repeat (10) @(posedge core_clk);
      xfer(0, OFS_STATUS, 0);
      chk(32'(q[3:0]), 32'(REQ_NR));
    end
    $display("command test done");
    sf <= 15'h0002;
    repeat (10) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[7:0]), 32'({4'h1, REQ_SF}));
    chk(32'(norm_out[0].data), 32'hA5);
    chk(32'(nfail), 32'h0);
    sf <= '0;
    repeat (10) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[11]), 32'h1);
    repeat (60) @(posedge core_clk);
    chk(32'(norm_out[0].data), 32'h40);
    chk(32'(sw_cnt), 32'h3);
    chk(32'(sw_dur), 32'h2);
    $display("fail and restore test done");
    xfer(1, OFS_CTRL, 32'h0000_0000);
    xfer(1, OFS_CMD, 32'h0000_0021);
    repeat (10) @(posedge core_clk);
    xfer(1, OFS_CMD, 32'(CMD_CLEAR));
    repeat (10) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[7:0]), 32'({4'h1, REQ_DNR}));
    chk(32'(norm_out[0].data), 32'hA5);
    xfer(1, OFS_CMD, 32'h0000_0010);
    repeat (10) @(posedge core_clk);
    chk(32'(norm_out[0].data), 32'h40);
    xfer(1, OFS_CMD, 32'(CMD_CLEAR));
    $display("non-revertive test done");
    xfer(1, OFS_CTRL, 32'h0000_0009);
    repeat (10) @(posedge core_clk);
    chk(32'(prot_out.data), 32'hE5);
    chk(32'(extra_out.data), 32'hA5);
    sd <= 15'h0008;
    repeat (10) @(posedge core_clk);
    xfer(0, OFS_STATUS, 0);
    chk(32'(q[7:0]), 32'({4'h3, REQ_SD}));
    chk(32'(norm_out[2].data), 32'hA5);
    chk(32'(prot_out.data), 32'h12);
    chk(32'(extra_out.data), 32'hFF);
    chk(32'(fail_action), 32'h1);
    $display("one for n test done");
    sd <= '0;
    repeat (40) @(posedge core_clk);
    xfer(1, OFS_CTRL, 32'h0000_0003);
    aps_req <= 13'h18A1;
    repeat (10) @(posedge core_clk);
    chk(32'(prot_out.data), 32'hFF);
    repeat (200) @(posedge core_clk);
    chk(32'(norm_out[4].data), 32'hA5);
    chk(32'(aps_tx), 32'h0000_04AB);
    chk(32'(pfail), 32'h1);
    chk(32'(sw_cnt), 32'h6);
    $display("bidirectional test done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
